// *** pkg/fres_pkg.sv ***
// Constants, types and register map of the flash row erase sequencer.
// Assumes one core clock at 250 MHz and an AXI4-Lite master with 32-bit data.
// Function
// - Smallest erasable unit is one 64-byte block of 32 words.
// - No single-word erase exists; every erase covers a whole block.
// - A core-started erase clears exactly one 64-byte block.
// - Block chosen by table pointer bits 21:6; bits 5:0 are ignored.
// - With erase select set, a launch erases instead of writing.
// - Start after a valid unlock, with wa and pms set and cfg clear, launches the addressed block erase, or a block write if erase select is clear.
// - The processor is stalled for the whole erase cycle.
// - An internal timer ends the cycle after about 2 ms, releasing stall.
package fres_pkg;
  // =====================================================
  // Timing
  localparam int CLK_MHZ = 250;
  localparam int ERASE_TIME_US = 2000;
  localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
  localparam int CNT_W = 20;

  // =====================================================
  // Geometry
  localparam int BLOCK_WORDS = 32;
  localparam int BLOCK_BYTES = 64;
  localparam int PTR_W = 22;
  localparam int BLK_LSB = 6;
  localparam int BLK_W = 16;

  // =====================================================
  // Register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_UNLOCK = 8'h04;
  localparam logic [7:0] ADDR_TPTR = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;

  // Control field positions
  localparam int PMS_BIT = 7;
  localparam int CFG_BIT = 6;
  localparam int ERASE_BIT = 4;
  localparam int WA_BIT = 2;
  localparam int START_BIT = 1;

  // Status field positions
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_ARMED_BIT = 1;
  localparam int ST_BLK_LSB = 16;

  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'haa;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // =====================================================
  // Types
  typedef struct packed {
    logic pms;
    logic cfg;
    logic erase;
    logic wa;
    logic start;
  } fres_ctrl_t;

  localparam fres_ctrl_t CTRL_RST = '{pms: 1'b0, cfg: 1'b0, erase: 1'b0, wa: 1'b0, start: 1'b0};

  typedef struct packed {
    logic erase;
    logic write;
    logic [BLK_W-1:0] block;
  } fres_op_t;

  typedef enum logic [2:0] {
    UL_IDLE = 3'b001,
    UL_KEY1 = 3'b010,
    UL_ARMED = 3'b100
  } fres_unlock_t;

  typedef enum logic [1:0] {
    SQ_IDLE = 2'b01,
    SQ_RUN = 2'b10
  } fres_seq_t;
endpackage : fres_pkg

// *** rtl/fres_top.sv ***
// Flash row erase sequencer: AXI4-Lite registers, unlock check, erase timer, core stall.
// Assumes the flash array acts on a one-cycle op pulse and the core honours cpu_stall.
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module fres_top #(
  parameter int ERASE_CYCLES = fres_pkg::ERASE_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // AXI4-Lite write channels
  input wire logic [fres_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [fres_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Flash array and core
  output fres_pkg::fres_op_t flash_op,
  output logic cpu_stall
);
  // =====================================================
  // State
  logic awready_r, awready_nxt, wready_r, wready_nxt, aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [fres_pkg::ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt, ptr_merged;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt, stall_r, stall_nxt, do_wr, launch;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  fres_pkg::fres_ctrl_t ctrl_r, ctrl_nxt, ctrl_new;
  logic [fres_pkg::PTR_W-1:0] tptr_r, tptr_nxt;
  logic [fres_pkg::BLK_W-1:0] last_blk_r, last_blk_nxt;
  fres_pkg::fres_unlock_t unlock_r, unlock_nxt;
  fres_pkg::fres_seq_t seq_r, seq_nxt;
  logic [fres_pkg::CNT_W-1:0] cnt_r, cnt_nxt, stall_len;
  fres_pkg::fres_op_t op_r, op_nxt;
  logic [7:0] wa_word, ra_word;

  assign wa_word = {awaddr_r[fres_pkg::ADDR_W-1:2], 2'h0};
  assign ra_word = {s_axi_araddr[fres_pkg::ADDR_W-1:2], 2'h0};

  // Byte lanes the master did not enable keep their old contents
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
    merge_bytes = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        merge_bytes[i*8 +: 8] = new_v[i*8 +: 8];
    end
  endfunction : merge_bytes

  // =====================================================
  // Next state
  always_comb
  begin
    awready_nxt = awready_r;
    wready_nxt = wready_r;
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    ctrl_nxt = ctrl_r;
    tptr_nxt = tptr_r;
    last_blk_nxt = last_blk_r;
    unlock_nxt = unlock_r;
    seq_nxt = seq_r;
    cnt_nxt = cnt_r;
    stall_nxt = stall_r;
    op_nxt = '{erase: 1'b0, write: 1'b0, block: op_r.block};
    launch = 1'b0;
    ctrl_new = ctrl_r;
    ptr_merged = merge_bytes({{(32-fres_pkg::PTR_W){1'b0}}, tptr_r}, wdata_r, wstrb_r);
    if (wstrb_r[0])
    begin
      ctrl_new.pms = wdata_r[fres_pkg::PMS_BIT];
      ctrl_new.cfg = wdata_r[fres_pkg::CFG_BIT];
      ctrl_new.erase = wdata_r[fres_pkg::ERASE_BIT];
      ctrl_new.wa = wdata_r[fres_pkg::WA_BIT];
      ctrl_new.start = wdata_r[fres_pkg::START_BIT];
    end

    // Address and data are taken independently, in either order
    if (s_axi_awvalid && awready_r)
    begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
      awready_nxt = 1'b0;
    end
    if (s_axi_wvalid && wready_r)
    begin
      w_got_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
      wready_nxt = 1'b0;
    end

    do_wr = aw_got_r && w_got_r && !bvalid_r;
    if (do_wr)
    begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = fres_pkg::RESP_OKAY;
      // Any other write between the keys and start breaks the unlock; reads leave it armed
      unlock_nxt = fres_pkg::UL_IDLE;
      case (wa_word)
        fres_pkg::ADDR_UNLOCK:
        begin
          if (wstrb_r[0] && wdata_r[7:0] == fres_pkg::UNLOCK_KEY1)
            unlock_nxt = fres_pkg::UL_KEY1;
          else if (wstrb_r[0] && unlock_r == fres_pkg::UL_KEY1 && wdata_r[7:0] == fres_pkg::UNLOCK_KEY2)
            unlock_nxt = fres_pkg::UL_ARMED;
        end
        fres_pkg::ADDR_CTRL:
        begin
          // Control is frozen while a cycle runs
          if (seq_r == fres_pkg::SQ_IDLE)
          begin
            ctrl_nxt = ctrl_new;
            if (ctrl_new.start && unlock_r == fres_pkg::UL_ARMED && ctrl_new.wa && ctrl_new.pms && !ctrl_new.cfg)
              launch = 1'b1;
            else
              ctrl_nxt.start = 1'b0;
          end
        end
        fres_pkg::ADDR_TPTR:
          tptr_nxt = ptr_merged[fres_pkg::PTR_W-1:0];
        fres_pkg::ADDR_STATUS: ;
        default:
          bresp_nxt = fres_pkg::RESP_DECERR;
      endcase
    end
    if (bvalid_r && s_axi_bready)
    begin
      bvalid_nxt = 1'b0;
      awready_nxt = 1'b1;
      wready_nxt = 1'b1;
    end

    if (launch)
    begin
      seq_nxt = fres_pkg::SQ_RUN;
      cnt_nxt = '0;
      stall_nxt = 1'b1;
      op_nxt.erase = ctrl_new.erase;
      op_nxt.write = !ctrl_new.erase;
      op_nxt.block = tptr_r[fres_pkg::PTR_W-1:fres_pkg::BLK_LSB];
      last_blk_nxt = tptr_r[fres_pkg::PTR_W-1:fres_pkg::BLK_LSB];
    end

    case (seq_r)
      fres_pkg::SQ_IDLE: ;
      fres_pkg::SQ_RUN:
      begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == fres_pkg::CNT_W'(ERASE_CYCLES - 1))
        begin
          seq_nxt = fres_pkg::SQ_IDLE;
          stall_nxt = 1'b0;
          ctrl_nxt.start = 1'b0;
        end
      end
      default:
      begin
        seq_nxt = fres_pkg::SQ_IDLE;
        stall_nxt = 1'b0;
      end
    endcase

    if (s_axi_arvalid && arready_r)
    begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rresp_nxt = fres_pkg::RESP_OKAY;
      rdata_nxt = '0;
      case (ra_word)
        fres_pkg::ADDR_CTRL:
        begin
          rdata_nxt[fres_pkg::PMS_BIT] = ctrl_r.pms;
          rdata_nxt[fres_pkg::CFG_BIT] = ctrl_r.cfg;
          rdata_nxt[fres_pkg::ERASE_BIT] = ctrl_r.erase;
          rdata_nxt[fres_pkg::WA_BIT] = ctrl_r.wa;
          rdata_nxt[fres_pkg::START_BIT] = ctrl_r.start;
        end
        fres_pkg::ADDR_UNLOCK: ;
        fres_pkg::ADDR_TPTR:
          rdata_nxt[fres_pkg::PTR_W-1:0] = tptr_r;
        fres_pkg::ADDR_STATUS:
        begin
          rdata_nxt[fres_pkg::ST_BUSY_BIT] = stall_r;
          rdata_nxt[fres_pkg::ST_ARMED_BIT] = (unlock_r == fres_pkg::UL_ARMED);
          rdata_nxt[fres_pkg::ST_BLK_LSB +: fres_pkg::BLK_W] = last_blk_r;
        end
        default:
          rresp_nxt = fres_pkg::RESP_DECERR;
      endcase
    end
    if (rvalid_r && s_axi_rready)
    begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
  end

  // =====================================================
  // Registers
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= fres_pkg::RESP_OKAY;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r <= fres_pkg::RESP_OKAY;
      rdata_r <= '0;
      ctrl_r <= fres_pkg::CTRL_RST;
      tptr_r <= '0;
      last_blk_r <= '0;
      unlock_r <= fres_pkg::UL_IDLE;
      seq_r <= fres_pkg::SQ_IDLE;
      cnt_r <= '0;
      stall_r <= 1'b0;
      op_r <= '0;
    end
    else
    begin
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      ctrl_r <= ctrl_nxt;
      tptr_r <= tptr_nxt;
      last_blk_r <= last_blk_nxt;
      unlock_r <= unlock_nxt;
      seq_r <= seq_nxt;
      cnt_r <= cnt_nxt;
      stall_r <= stall_nxt;
      op_r <= op_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign flash_op = op_r;
  assign cpu_stall = stall_r;

  // =====================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // Counts stall cycles so the timer length can be checked exactly
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      stall_len <= '0;
    else
      stall_len <= stall_r ? stall_len + 1'b1 : '0;
  end

  sequence s_armed_start;
    do_wr && wa_word == fres_pkg::ADDR_CTRL && unlock_r == fres_pkg::UL_ARMED && seq_r == fres_pkg::SQ_IDLE
      && ctrl_new.start && ctrl_new.wa && ctrl_new.pms && !ctrl_new.cfg;
  endsequence
  sequence s_op_issued;
    cpu_stall && (flash_op.erase || flash_op.write);
  endsequence

  a_launch_on_start: assert property (s_armed_start |=> s_op_issued)
    else $error("armed start did not launch");
  a_launch_needs_key: assert property ($rose(cpu_stall) |-> $past(unlock_r) == fres_pkg::UL_ARMED)
    else $error("launch without unlock");
  a_launch_write_allow: assert property ($rose(cpu_stall) |-> ctrl_r.wa)
    else $error("launch with write allow clear");
  a_erase_not_write: assert property (s_armed_start ##0 ctrl_new.erase |=> flash_op.erase && !flash_op.write)
    else $error("erase select ignored");
  a_block_from_ptr: assert property (flash_op.erase |-> flash_op.block == $past(tptr_r[21:6]))
    else $error("wrong block address");
  a_single_block: assert property (flash_op.erase |=> (!flash_op.erase && cpu_stall) [*8])
    else $error("more than one block op in a cycle");
  a_timer_length: assert property ($fell(cpu_stall) |-> stall_len == fres_pkg::CNT_W'(ERASE_CYCLES))
    else $error("erase cycle length wrong");
  a_start_clears: assert property ($fell(cpu_stall) |-> !ctrl_r.start && seq_r == fres_pkg::SQ_IDLE)
    else $error("start bit not cleared at end");
  a_stall_tracks: assert property (flash_op.erase || flash_op.write |-> cpu_stall ##1 cpu_stall)
    else $error("core not stalled during cycle");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
endmodule : fres_top

// *** bench/tb.sv ***
// Self-checking bench for the flash row erase sequencer top module.
// Assumes the top alone on an AXI4-Lite master, with a short erase timer.
`timescale 1ns/1ps
module tb;
  localparam int ERASE_N = 20;
  localparam int TIMEOUT = 5000;
  logic core_clk = 1'h0;
  logic rstn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_stall;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd;
  fres_pkg::fres_op_t flash_op;
  int err_count = 0, total_checks = 0, cycles = 0, n_erase = 0, n_write = 0, n_stall = 0, b_wait = 0;
  logic [3:0] strb = 4'hf;
  logic [15:0] last_blk = 16'h0;
  logic [31:0] ptr = 32'h0015a9e7;
  // Refused launch table: first key, second key, extra write between, control value
  logic [7:0] k1_t [7] = '{8'h00, 8'haa, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55};
  logic [7:0] k2_t [7] = '{8'h00, 8'h55, 8'h5a, 8'haa, 8'haa, 8'haa, 8'haa};
  logic mid_t [7] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0};
  logic [31:0] ctl_t [7] = '{32'h96, 32'h96, 32'h96, 32'h96, 32'h92, 32'h16, 32'hd6};

  fres_top #(.ERASE_CYCLES(ERASE_N)) dut (
    .core_clk(core_clk), .rstn(rstn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .flash_op(flash_op), .cpu_stall(cpu_stall)
  );

  always #2 core_clk = ~core_clk;

  // =====================================================
  // Monitor and timeout
  // Outputs are registered, so values read at the edge are the ones sampled there
  always @(posedge core_clk)
  begin
    cycles++;
    if (rstn && flash_op.erase)
    begin
      n_erase++;
      last_blk = flash_op.block;
    end
    if (rstn && flash_op.write)
      n_write++;
    if (rstn && cpu_stall)
      n_stall++;
    if (cycles >= TIMEOUT)
    begin
      err_count++;
      print_verdict();
    end
  end

  // =====================================================
  // Bus tasks
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'h0;
    w_done = 1'h0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= d;
    s_axi_wstrb <= strb;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= (b_wait == 0);
    while (!(aw_done && w_done))
    begin
      @(posedge core_clk);
      if (!aw_done && s_axi_awready)
      begin
        aw_done = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w_done && s_axi_wready)
      begin
        w_done = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    // A late bready lets the response hold be watched
    if (b_wait > 0)
    begin
      repeat (b_wait) @(posedge core_clk);
      s_axi_bready <= 1'h1;
    end
    do @(posedge core_clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge core_clk);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge core_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge core_clk);
  endtask : axi_read

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic arm_and_start(input logic [7:0] k1, input logic [7:0] k2, input logic mid,
                               input logic [31:0] ctl);
    axi_write(fres_pkg::ADDR_UNLOCK, {24'h0, k1}, resp);
    axi_write(fres_pkg::ADDR_UNLOCK, {24'h0, k2}, resp);
    if (mid)
      axi_write(fres_pkg::ADDR_TPTR, ptr, resp);
    axi_write(fres_pkg::ADDR_CTRL, ctl, resp);
  endtask : arm_and_start

  // Waits past any cycle, then checks pulses, stall length and the start bit
  task automatic expect_run(input int e, input int w);
    repeat (ERASE_N + 10) @(posedge core_clk);
    chk("erase pulses", 32'(e), 32'(n_erase));
    chk("write pulses", 32'(w), 32'(n_write));
    chk("stall cycles", 32'((e + w) * ERASE_N), 32'(n_stall));
    axi_read(fres_pkg::ADDR_CTRL, rd, resp);
    chk("start bit", 32'h0, {31'h0, rd[fres_pkg::START_BIT]});
    n_erase = 0;
    n_write = 0;
    n_stall = 0;
  endtask : expect_run

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict

  // =====================================================
  // Main sequence
  initial
  begin
    repeat (3) @(posedge core_clk);
    rstn <= 1'h1;
    @(posedge core_clk);
    axi_write(fres_pkg::ADDR_TPTR, 32'hffffffff, resp);
    axi_read(fres_pkg::ADDR_TPTR, rd, resp);
    chk("pointer width", 32'h003fffff, rd);
    strb = 4'h2;
    axi_write(fres_pkg::ADDR_TPTR, 32'h00001200, resp);
    strb = 4'hf;
    chk("pointer bresp", {30'h0, fres_pkg::RESP_OKAY}, {30'h0, resp});
    axi_read(fres_pkg::ADDR_TPTR, rd, resp);
    chk("pointer lane", 32'h003f12ff, rd);
    b_wait = 3;
    axi_write(8'h20, 32'h1, resp);
    b_wait = 0;
    chk("unmapped bresp", {30'h0, fres_pkg::RESP_DECERR}, {30'h0, resp});
    axi_read(8'h20, rd, resp);
    chk("unmapped rresp", {30'h0, fres_pkg::RESP_DECERR}, {30'h0, resp});
    axi_write(fres_pkg::ADDR_TPTR, ptr, resp);
    // Bad keys, key order, extra write, and each missing enable must not launch
    for (int i = 0; i < 7; i++)
    begin
      arm_and_start(k1_t[i], k2_t[i], mid_t[i], ctl_t[i]);
      expect_run(0, 0);
    end
    // Valid erase with nonzero low pointer bits
    axi_write(fres_pkg::ADDR_UNLOCK, 32'h55, resp);
    axi_write(fres_pkg::ADDR_UNLOCK, 32'haa, resp);
    axi_read(fres_pkg::ADDR_UNLOCK, rd, resp);
    chk("unlock readback", 32'h0, rd);
    axi_read(fres_pkg::ADDR_STATUS, rd, resp);
    chk("armed", 32'h1, {31'h0, rd[fres_pkg::ST_ARMED_BIT]});
    axi_write(fres_pkg::ADDR_CTRL, 32'h96, resp);
    axi_read(fres_pkg::ADDR_STATUS, rd, resp);
    chk("busy in cycle", 32'h1, {31'h0, rd[fres_pkg::ST_BUSY_BIT]});
    chk("status block", {16'h0, ptr[21:6]}, {16'h0, rd[31:16]});
    axi_write(fres_pkg::ADDR_CTRL, 32'h0, resp);
    expect_run(1, 0);
    chk("control frozen", 32'h94, rd);
    chk("erased block", {16'h0, ptr[21:6]}, {16'h0, last_blk});
    // Erase select clear gives a write pulse instead
    arm_and_start(8'h55, 8'haa, 1'h0, 32'h86);
    expect_run(0, 1);
    print_verdict();
  end
endmodule : tb
